// file: bce_branch_eval.sv
// Branch condition evaluator with an AXI4-Lite statistics/status slave.
// Assumes opcode, strobes and flags come from logic on clk_i.
//
// Function
// - The condition field is taken from bits 7:4 of the first byte of both conditional jump kinds.
// - Only carry, zero, sign and overflow enter the test; half-carry and decimal flags are ignored.
// - Field 0000 never jumps and field 1000 always jumps, whatever the flags.
// - Field 0001 jumps when sign xor overflow is one, field 1001 when it is zero.
// - Field 0010 jumps when zero or (sign xor overflow) is one, field 1010 when it is zero.
// - Field 0011 jumps when carry or zero is one, field 1011 only when both are zero.
// - Fields 0100-0111 jump on overflow, sign, zero, carry set; 1100-1111 on the same flags clear.
// - The decision depends only on the 4-bit field, so alternative spellings behave identically.
// - The jump is taken only when the test is true, otherwise the next instruction follows.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module bce_branch_eval (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] opcode_i,
  input wire logic absolute_conditional_jump_i,
  input wire logic relative_conditional_jump_i,
  input wire logic [7:0] flags_i,
  output logic branch_taken_o,
  input wire logic [bce_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bce_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------
  function automatic logic cond_true(input logic [3:0] branch_predicate_field, input logic [7:0] flags);
    logic c;
    logic z;
    logic s;
    logic v;
    logic base;
    c = flags[bce_pkg::FLAG_CARRY];
    z = flags[bce_pkg::FLAG_ZERO];
    s = flags[bce_pkg::FLAG_SIGN];
    v = flags[bce_pkg::FLAG_OVERFLOW];
    // Low three bits pick test
    // Top bit only inverts, so each pair shares one test term
    case (branch_predicate_field[2:0])
      bce_pkg::COND_NEVER[2:0]: base = 1'b0;
      bce_pkg::COND_LT[2:0]: base = s ^ v;
      bce_pkg::COND_LE[2:0]: base = z | (s ^ v);
      bce_pkg::COND_ULE[2:0]: base = c | z;
      bce_pkg::COND_OV[2:0]: base = v;
      bce_pkg::COND_MINUS[2:0]: base = s;
      bce_pkg::COND_ZERO[2:0]: base = z;
      bce_pkg::COND_CARRY[2:0]: base = c;
      default: base = 1'b0;
    endcase
    return base ^ branch_predicate_field[3];
  endfunction

  logic cond_jump;
  logic [3:0] branch_predicate_field;
  logic cond_met;
  logic decision;

  always_comb begin
    cond_jump = absolute_conditional_jump_i | relative_conditional_jump_i;
    branch_predicate_field = opcode_i[bce_pkg::COND_HI:bce_pkg::COND_LO];
    // Only C Z S V used
    cond_met = cond_true(branch_predicate_field, flags_i);
    decision = cond_jump & cond_met;
  end

  // Same-cycle decision
  // The program counter needs this in the decode cycle, so it is not registered
  assign branch_taken_o = decision;

  // ------------------------------------------------------------
  // Statistics and status state
  // ------------------------------------------------------------
  logic stats_en;
  logic [31:0] taken_cnt;
  logic [31:0] skip_cnt;
  logic [3:0] last_field;
  logic last_taken;
  logic last_relative;
  logic next_stats_en;
  logic [31:0] next_taken_cnt;
  logic [31:0] next_skip_cnt;
  logic [3:0] next_last_field;
  logic next_last_taken;
  logic next_last_relative;

  // ------------------------------------------------------------
  // AXI4-Lite slave state
  // ------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic [bce_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic next_aw_got;
  logic next_w_got;
  logic [bce_pkg::ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_wr_data;
  logic [3:0] next_wr_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic clear_req;

  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Write commits once both halves are held and no response is pending
    if (aw_got && w_got && !s_axi_bvalid) begin
      do_write = 1'b1;
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      case (wr_addr)
        bce_pkg::REG_CTRL, bce_pkg::REG_STATUS, bce_pkg::REG_TAKEN_CNT, bce_pkg::REG_SKIP_CNT: begin
          next_bresp = bce_pkg::RESP_OKAY;
        end
        default: next_bresp = bce_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = bce_pkg::RESP_OKAY;
      case (s_axi_araddr)
        bce_pkg::REG_CTRL: next_rdata = {31'h0, stats_en};
        bce_pkg::REG_STATUS: next_rdata = {26'h0, last_relative, last_taken, last_field};
        bce_pkg::REG_TAKEN_CNT: next_rdata = taken_cnt;
        bce_pkg::REG_SKIP_CNT: next_rdata = skip_cnt;
        default: begin
          next_rdata = 32'h0;
          next_rresp = bce_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bce_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= bce_pkg::RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ------------------------------------------------------------
  // Statistics update
  // ------------------------------------------------------------
  always_comb begin
    next_stats_en = stats_en;
    next_last_field = last_field;
    next_last_taken = last_taken;
    next_last_relative = last_relative;
    clear_req = 1'b0;
    if (do_write && wr_addr == bce_pkg::REG_CTRL && wr_strb[0]) begin
      next_stats_en = wr_data[bce_pkg::CTRL_STATS_EN];
      clear_req = wr_data[bce_pkg::CTRL_CLEAR];
    end
    // Clear first, then count, so a jump in the clear cycle is kept
    next_taken_cnt = clear_req ? 32'h0 : taken_cnt;
    next_skip_cnt = clear_req ? 32'h0 : skip_cnt;
    if (cond_jump && stats_en) begin
      next_last_field = branch_predicate_field;
      next_last_taken = decision;
      next_last_relative = relative_conditional_jump_i;
      if (decision) begin
        next_taken_cnt = next_taken_cnt + 32'h1;
      end else begin
        next_skip_cnt = next_skip_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stats_en <= bce_pkg::CTRL_STATS_RESET;
      taken_cnt <= 32'h0;
      skip_cnt <= 32'h0;
      last_field <= 4'h0;
      last_taken <= 1'b0;
      last_relative <= 1'b0;
    end else begin
      stats_en <= next_stats_en;
      taken_cnt <= next_taken_cnt;
      skip_cnt <= next_skip_cnt;
      last_field <= next_last_field;
      last_taken <= next_last_taken;
      last_relative <= next_last_relative;
    end
  end

endmodule

// file: bce_pkg.sv
// Shared constants for the branch condition evaluator.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit flags byte.
package bce_pkg;

  // ------------------------------------------------------------
  // Opcode and flag layout
  // ------------------------------------------------------------
  localparam int unsigned COND_HI = 7;
  localparam int unsigned COND_LO = 4;
  localparam int unsigned FLAG_CARRY = 7;
  localparam int unsigned FLAG_ZERO = 6;
  localparam int unsigned FLAG_SIGN = 5;
  localparam int unsigned FLAG_OVERFLOW = 4;

  // ------------------------------------------------------------
  // Condition field encodings
  // ------------------------------------------------------------
  localparam logic [3:0] COND_NEVER = 4'h0;
  localparam logic [3:0] COND_LT = 4'h1;
  localparam logic [3:0] COND_LE = 4'h2;
  localparam logic [3:0] COND_ULE = 4'h3;
  localparam logic [3:0] COND_OV = 4'h4;
  localparam logic [3:0] COND_MINUS = 4'h5;
  localparam logic [3:0] COND_ZERO = 4'h6;
  localparam logic [3:0] COND_CARRY = 4'h7;
  localparam logic [3:0] COND_ALWAYS = 4'h8;
  localparam logic [3:0] COND_GE = 4'h9;
  localparam logic [3:0] COND_GT = 4'ha;
  localparam logic [3:0] COND_UGT = 4'hb;
  localparam logic [3:0] COND_NOV = 4'hc;
  localparam logic [3:0] COND_PLUS = 4'hd;
  localparam logic [3:0] COND_NZERO = 4'he;
  localparam logic [3:0] COND_NCARRY = 4'hf;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TAKEN_CNT = 8'h08;
  localparam logic [7:0] REG_SKIP_CNT = 8'h0c;
  localparam int unsigned CTRL_STATS_EN = 0;
  localparam int unsigned CTRL_CLEAR = 1;
  localparam logic CTRL_STATS_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: bce_cpu_model.sv
// CPU side model: decoder strobes, opcode byte and flags register.
// Assumes requests arrive on clk_i by non-blocking assignment.
`timescale 1ns/10ps
module bce_cpu_model (
  input wire logic clk_i,
  input wire logic [3:0] field_i,
  input wire logic [3:0] flag_hi_i,
  input wire logic [1:0] kind_i,
  output logic [7:0] opcode_o = 8'h00,
  output logic abs_o = 1'b0,
  output logic rel_o = 1'b0,
  output logic [7:0] flags_o = 8'h00
);
  logic [3:0] junk = 4'h0;
  // Low nibbles churn every cycle so stale bits never look meaningful
  always @(posedge clk_i) begin
    junk <= junk + 4'h3;
    opcode_o <= {field_i, junk};
    flags_o <= {flag_hi_i, ~junk};
    {rel_o, abs_o} <= kind_i;
  end
endmodule

// file: bce_branch_eval_properties.sv
// Checker on the decision port of the branch evaluator.
// Assumes flags_i carries carry, zero, sign, overflow in bits 7:4.
`timescale 1ns/10ps
module bce_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] opcode_i,
  input wire logic absolute_conditional_jump_i,
  input wire logic relative_conditional_jump_i,
  input wire logic [7:0] flags_i,
  input wire logic branch_taken_o
);
  logic en, c, z, s, v;
  logic [3:0] f;
  assign en = absolute_conditional_jump_i | relative_conditional_jump_i;
  assign f = opcode_i[7:4];
  assign {c, z, s, v} = flags_i[7:4];
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_idle; !en |-> !branch_taken_o; endproperty
  a_idle: assert property (p_idle) else $error("taken without strobe");
  property p_never; f == 4'h0 |-> !branch_taken_o; endproperty
  a_never: assert property (p_never) else $error("field 0 taken");
  property p_always; en && f == 4'h8 |-> branch_taken_o; endproperty
  a_always: assert property (p_always) else $error("field 8 not taken");
  property p_lt; en && f[2:0] == 3'h1 |-> branch_taken_o == (s ^ v ^ f[3]); endproperty
  a_lt: assert property (p_lt) else $error("signed less test wrong");
  property p_le; en && f[2:0] == 3'h2 |-> branch_taken_o == ((z | (s ^ v)) ^ f[3]); endproperty
  a_le: assert property (p_le) else $error("signed less-equal test wrong");
  property p_ule; en && f[2:0] == 3'h3 |-> branch_taken_o == ((c | z) ^ f[3]); endproperty
  a_ule: assert property (p_ule) else $error("unsigned test wrong");
  property p_single; en && f[2] |-> branch_taken_o == (flags_i[{1'b1, f[1:0]}] ^ f[3]); endproperty
  a_single: assert property (p_single) else $error("single flag test wrong");
  // Low flag and opcode bits churn here, but en never stays high two cycles, so this catches a leak of them only while en is low
  property p_stable;
    $stable(f) && $stable(flags_i[7:4]) && $stable(en) |-> $stable(branch_taken_o);
  endproperty
  a_stable: assert property (p_stable) else $error("decision moved with unused bits");
endmodule
bind bce_branch_eval bce_checker u_bce_checker (.clk_i, .reset_i, .opcode_i, .absolute_conditional_jump_i,
  .relative_conditional_jump_i, .flags_i, .branch_taken_o);

// file: testbench.sv
// Bench: CPU model feeds the evaluator, AXI4-Lite tasks read its registers.
// Assumes bce_pkg, the CPU model and the checker are compiled first.
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic stats = 1'b1;
  logic [3:0] strb = 4'hf;
  logic [3:0] fld = 4'h0, fl = 4'h0, s_axi_wstrb = 4'h0;
  logic [1:0] kind = 2'h0, s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] opcode_i, flags_i, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic absolute_conditional_jump_i, relative_conditional_jump_i, branch_taken_o;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  int fail_count = 0, n_compared = 0, n_take = 0, n_skip = 0;
  always #20 clk_i = ~clk_i;
  bce_cpu_model u_bce_cpu_model (.clk_i, .field_i(fld), .flag_hi_i(fl), .kind_i(kind), .opcode_o(opcode_i),
    .abs_o(absolute_conditional_jump_i), .rel_o(relative_conditional_jump_i), .flags_o(flags_i));
  bce_branch_eval u_bce_branch_eval (.clk_i, .reset_i, .opcode_i, .absolute_conditional_jump_i,
    .relative_conditional_jump_i, .flags_i, .branch_taken_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // --------------------------------------------------------
  // Tasks
  // --------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string n);
    @(posedge clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(n, rdat, e);
    chk("rresp", rsp, er);
  endtask
  // Flag nibble is {carry, zero, sign, overflow}; field bit 3 inverts
  function automatic logic cond(input logic [3:0] f, input logic [3:0] g);
    logic [7:0] t;
    t = {g[3], g[2], g[1], g[0], g[3] | g[2], g[2] | (g[1] ^ g[0]), g[1] ^ g[0], 1'b0};
    return t[f[2:0]] ^ f[3];
  endfunction
  // Strobe stands exactly one cycle, so each call counts once
  task automatic jump(input logic [3:0] f, input logic [3:0] g, input logic [1:0] k);
    logic e;
    e = cond(f, g) & (k != 2'h0);
    @(posedge clk_i);
    fld <= f;
    fl <= g;
    kind <= k;
    @(posedge clk_i);
    kind <= 2'h0;
    @(negedge clk_i);
    chk("taken", branch_taken_o, e);
    if (stats && k != 2'h0 && e) n_take++;
    if (stats && k != 2'h0 && !e) n_skip++;
  endtask
  // --------------------------------------------------------
  // Tests
  // --------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rchk(bce_pkg::REG_CTRL, 32'h1, bce_pkg::RESP_OKAY, "ctrl reset");
    rchk(bce_pkg::REG_TAKEN_CNT, 32'h0, bce_pkg::RESP_OKAY, "taken reset");
    for (int i = 0; i < 1024; i++) jump(i[3:0], i[7:4], i[9:8]);
    rchk(bce_pkg::REG_TAKEN_CNT, n_take, bce_pkg::RESP_OKAY, "taken count");
    rchk(bce_pkg::REG_SKIP_CNT, n_skip, bce_pkg::RESP_OKAY, "skip count");
    wr(bce_pkg::REG_CTRL, 32'h0, bce_pkg::RESP_OKAY);
    stats = 1'b0;
    jump(bce_pkg::COND_ALWAYS, 4'h0, 2'h1);
    rchk(bce_pkg::REG_TAKEN_CNT, n_take, bce_pkg::RESP_OKAY, "frozen count");
    wr(bce_pkg::REG_CTRL, 32'h3, bce_pkg::RESP_OKAY);
    {stats, n_take, n_skip} = {1'b1, 64'h0};
    rchk(bce_pkg::REG_CTRL, 32'h1, bce_pkg::RESP_OKAY, "ctrl clear");
    jump(bce_pkg::COND_LT, 4'h2, 2'h2);
    rchk(bce_pkg::REG_STATUS, 32'h31, bce_pkg::RESP_OKAY, "status");
    rchk(bce_pkg::REG_TAKEN_CNT, 32'h1, bce_pkg::RESP_OKAY, "count after clear");
    wr(8'h10, 32'h1, bce_pkg::RESP_SLVERR);
    rchk(8'h10, 32'h0, bce_pkg::RESP_SLVERR, "unmapped");
    // Low strobe lane off: enable and clear must both be ignored
    strb = 4'he;
    wr(bce_pkg::REG_CTRL, 32'h2, bce_pkg::RESP_OKAY);
    strb = 4'hf;
    rchk(bce_pkg::REG_CTRL, 32'h1, bce_pkg::RESP_OKAY, "ctrl strobe");
    rchk(bce_pkg::REG_TAKEN_CNT, 32'h1, bce_pkg::RESP_OKAY, "count kept");
    report_and_stop();
  end
  // Tests need about 2100 cycles; allow over four times that
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule
